// ---- acc_pkg.sv ----
package acc_pkg;
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned CONV_TIME_NS       = 4000;
  localparam int unsigned CONV_CYCLES        = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned POWER_DOWN_REQUEST_N_RECOVER_US    = 100;
  localparam int unsigned POWER_DOWN_REQUEST_N_RECOVER_CYC   = POWER_DOWN_REQUEST_N_RECOVER_US * CLK_MHZ;
  localparam int unsigned SHDN_RECOVER_MS    = 13;
  localparam int unsigned SHDN_RECOVER_CYC   = SHDN_RECOVER_MS * 1000 * CLK_MHZ;
  localparam int unsigned SET_SKEW_NS        = 500;
  localparam int unsigned SET_SKEW_CYC       = (SET_SKEW_NS * CLK_MHZ) / 1000;
  localparam int unsigned RESET_PULSE_CYC    = 4;
  localparam int unsigned CH_COUNT           = 8;
  localparam int unsigned SET_A_MASK_LSB     = 0;
  localparam int unsigned SET_B_MASK_LSB     = 4;
  localparam int unsigned SET_WIDTH          = 4;
  localparam int unsigned SAMPLE_W           = 16;
  localparam logic [1:0] IF_PARALLEL         = 2'h0;
  localparam logic [1:0] IF_SERIAL           = 2'h1;
  localparam logic [1:0] IF_BYTE             = 2'h3;
  // Avalon register map of the host controller
  localparam logic [3:0] REG_CTRL            = 4'h0;
  localparam logic [3:0] REG_STATUS          = 4'h4;
  localparam logic [3:0] REG_SKEW            = 4'h8;
  localparam int unsigned CTRL_POWER_DOWN_REQUEST_N_N        = 0;
  localparam int unsigned CTRL_RANGE         = 1;
  localparam int unsigned CTRL_IF_SEL        = 2;
  localparam int unsigned CTRL_BYTE_SEL      = 3;
  localparam int unsigned CTRL_SPLIT         = 4;
  localparam int unsigned CTRL_CONVERT       = 5;
  localparam int unsigned CTRL_RESET         = 6;
  localparam logic [31:0] CTRL_RESET_VALUE   = 32'h0000_0003;
  localparam logic [31:0] SKEW_RESET_VALUE   = 32'h0000_0010;
  typedef enum logic [2:0] {ACC_OFF, ACC_SHDN, ACC_POWER_DOWN_REQUEST_N, ACC_WAKE, ACC_IDLE, ACC_CONV} acc_state_e;
  typedef enum logic [2:0] {ACH_IDLE, ACH_RST, ACH_TRIG_A, ACH_GAP, ACH_TRIG_B, ACH_WAIT} ach_state_e;
endpackage

// ---- acc_link_if.sv ----
`timescale 1ns/1ps
interface acc_link_if;
  logic power_down_request_n;
  logic range;
  logic adc_reset;
  logic sample_trigger_a;
  logic sample_trigger_b;
  logic interface_select;
  logic byte_mode_select;
  logic busy;
  modport device (input power_down_request_n, range, adc_reset, sample_trigger_a, sample_trigger_b,
                  interface_select, byte_mode_select, output busy);
  modport host   (output power_down_request_n, range, adc_reset, sample_trigger_a, sample_trigger_b,
                  interface_select, byte_mode_select, input busy);
endinterface

// ---- acc_sync.sv ----
`timescale 1ns/1ps
module acc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } acc_sync_s;
  acc_sync_s r;
  acc_sync_s next_r;
  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // A change counts only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.q[i] = r.s3[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign q = r.q;
endmodule

// ---- acc_device.sv ----
`timescale 1ns/1ps
// Operation
// RL1: High request pin runs normal, low powers down
// RL2: Power-down: range high standby, low shutdown
// RL3: Standby keeps reference, wake about 100 us
// RL4: Shutdown powers everything, wake about 13 ms
// RL5: Host waits wake time, then resets
// RL6: Host resets after supplies come up
// RL7: Common trigger holds all channels together
// RL8: Busy brackets whole internal conversion
// RL9: Busy fall returns holds to track
// RL10: Results readable after busy falls
// RL11: Host splits sets only without oversampling
// RL12: Trigger A holds set one, B two
// RL13: Split: busy rises on later edge
// RL14: Host keeps set skew within limit
// RL15: Readout identical for common or split
// RL16: Every channel converted and read out
// RL17: Straps choose parallel, serial or byte
// RL18: Range selects 10 V or 5 V span
// RL19: Full conversion lasts 4 us
// RL20: Previous results readable while busy
// RL21: Trigger edge ignored while busy high
module acc_device
  import acc_pkg::*;
#(
  parameter int unsigned CONV_CYC   = CONV_CYCLES,
  parameter int unsigned POWER_DOWN_REQUEST_N_CYC   = POWER_DOWN_REQUEST_N_RECOVER_CYC,
  parameter int unsigned SHDN_CYC   = SHDN_RECOVER_CYC,
  parameter int unsigned CHANNELS   = CH_COUNT
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  acc_link_if.device                 link,
  output logic [CHANNELS-1:0]        hold,
  output logic [1:0]                 interface_mode,
  output logic                       span_10v,
  output logic                       ready,
  output logic                       results_valid,
  output logic [31:0]                conversion_count
);
  localparam int unsigned WAKE_MAX = (SHDN_CYC > POWER_DOWN_REQUEST_N_CYC) ? SHDN_CYC : POWER_DOWN_REQUEST_N_CYC;
  localparam int unsigned CNT_MAX  = (WAKE_MAX > CONV_CYC) ? WAKE_MAX : CONV_CYC;
  localparam int unsigned CNT_W    = $clog2(CNT_MAX + 1);
  localparam int unsigned HALF  = CHANNELS / 2;

  // Every link pin is asynchronous here; a one-cycle pulse is filtered out
  logic [6:0] pins;
  acc_sync #(.W(7)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({link.power_down_request_n, link.range, link.adc_reset, link.sample_trigger_a,
           link.sample_trigger_b, link.interface_select, link.byte_mode_select}),
    .q   (pins)
  );
  wire power_down_request_n_n = pins[6];
  wire rng    = pins[5];
  wire arst   = pins[4];
  wire trg_a  = pins[3];
  wire trg_b  = pins[2];
  wire if_sel = pins[1];
  wire by_sel = pins[0];
  // Parallel 00, serial 10, byte 11; the byte strap alone leaves parallel
  wire [1:0] strap_mode = {if_sel, if_sel & by_sel};

  // Whole device state, registered in one place
  typedef struct packed {
    acc_state_e          st;
    logic [CNT_W-1:0]    cnt;
    logic                prev_a;
    logic                prev_b;
    logic                got_a;
    logic                got_b;
    logic                was_shdn;
    logic [CHANNELS-1:0] hold;
    logic [1:0]          mode;
    logic                span;
    logic                busy;
    logic                ready;
    logic                valid;
    logic [31:0]         count;
  } acc_dev_s;
  acc_dev_s r;
  acc_dev_s next_r;

  always_comb begin
    logic rise_a;
    logic rise_b;
    rise_a        = 1'b0;
    rise_b        = 1'b0;
    next_r        = r;
    next_r.prev_a = trg_a;
    next_r.prev_b = trg_b;
    rise_a        = trg_a & ~r.prev_a;
    rise_b        = trg_b & ~r.prev_b;

    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - CNT_W'(1);
    end
    next_r.span = rng; // RL18
    case (r.st)
      ACC_OFF: begin
        // Nothing is usable until the host resets the part
        next_r.ready = 1'b0;
        if (arst) begin
          next_r.st    = ACC_IDLE; // RL6
          next_r.mode  = strap_mode; // RL17
          next_r.hold  = '0;
          next_r.got_a = 1'b0;
          next_r.got_b = 1'b0;
        end
      end

      ACC_SHDN, ACC_POWER_DOWN_REQUEST_N: begin
        // Holds are released; nothing samples while powered down
        next_r.ready = 1'b0;
        next_r.hold  = '0;
        if (power_down_request_n_n) begin // RL1
          next_r.st  = ACC_WAKE;
          next_r.was_shdn = (r.st == ACC_SHDN);
          next_r.cnt = (r.st == ACC_SHDN) ? CNT_W'(SHDN_CYC) : CNT_W'(POWER_DOWN_REQUEST_N_CYC); // RL3 RL4
        end
      end

      ACC_WAKE: begin
        // Dropping the request mid-wake restarts the power-down
        if (!power_down_request_n_n) begin
          next_r.st = rng ? ACC_POWER_DOWN_REQUEST_N : ACC_SHDN; // RL2
        end else if (r.cnt == '0) begin
          // A shutdown loses its configuration, so a reset must follow
          next_r.st = r.was_shdn ? ACC_OFF : ACC_IDLE; // RL5
          next_r.ready = ~r.was_shdn;
        end
      end

      ACC_IDLE: begin
        next_r.ready = 1'b1;
        if (!power_down_request_n_n) begin
          next_r.st    = rng ? ACC_POWER_DOWN_REQUEST_N : ACC_SHDN; // RL1 RL2
          next_r.ready = 1'b0;
          // A half-armed split trigger must not survive power-down
          next_r.got_a = 1'b0;
          next_r.got_b = 1'b0;
        end else begin
          if (rise_a) begin
            next_r.got_a = 1'b1;
            next_r.hold[HALF-1:0] = '1; // RL7 RL12
          end
          if (rise_b) begin
            next_r.got_b = 1'b1;
            next_r.hold[CHANNELS-1:HALF] = '1; // RL7 RL12
          end
          if ((r.got_a | rise_a) & (r.got_b | rise_b)) begin
            // Starts on the later edge, or the shared one
            next_r.st    = ACC_CONV; // RL13 RL15
            next_r.busy  = 1'b1; // RL8
            next_r.cnt   = CNT_W'(CONV_CYC); // RL19
            next_r.got_a = 1'b0;
            next_r.got_b = 1'b0;
          end
        end
      end

      ACC_CONV: begin
        // Edges during busy are dropped, not queued
        if (r.cnt == CNT_W'(1)) begin // RL21
          next_r.st    = ACC_IDLE;
          next_r.busy  = 1'b0; // RL8
          next_r.hold  = '0; // RL9
          // Results stay readable while the next conversion runs
          next_r.valid = 1'b1; // RL10 RL20
          next_r.count = r.count + 32'h1; // RL16
        end
      end

      default: next_r.st = ACC_OFF;
    endcase
    // A reset while powered down is ignored: there is no core to set up
    if (arst && r.st != ACC_OFF && r.st != ACC_SHDN && r.st != ACC_POWER_DOWN_REQUEST_N) begin
      next_r.st    = ACC_IDLE;
      next_r.mode  = strap_mode; // RL17
      next_r.busy  = 1'b0;
      next_r.hold  = '0;
      next_r.got_a = 1'b0;
      next_r.got_b = 1'b0;
      next_r.cnt   = '0;
    end
  end

  // Reset leaves the part in OFF until the host pulses its reset pin
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link.busy        = r.busy;
  assign hold             = r.hold;
  assign interface_mode   = r.mode;
  assign span_10v         = r.span;
  assign ready            = r.ready;
  assign results_valid    = r.valid;
  assign conversion_count = r.count;
endmodule

// ---- acc_host.sv ----
`timescale 1ns/1ps
module acc_host
  import acc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  acc_link_if.host         link,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  logic busy_s;
  acc_sync #(.W(1)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (link.busy),
    .q   (busy_s)
  );

  typedef struct packed {
    ach_state_e  st;
    logic [31:0] ctrl;
    logic [31:0] skew;
    logic [31:0] cnt;
    logic        rstp;
    logic        ta;
    logic        tb;
    logic        seen_busy;
    logic        done;
    logic [31:0] rdata;
    logic        ack;
  } ach_s;
  ach_s r;
  ach_s next_r;

  always_comb begin
    next_r     = r;
    next_r.ack = 1'b0;
    if (r.cnt != 32'h0) begin
      next_r.cnt = r.cnt - 32'h1;
    end
    // One wait state on every access, then answer
    if ((avs_read | avs_write) && !r.ack) begin
      next_r.ack = 1'b1;
      case (avs_address)
        REG_CTRL:   next_r.rdata = r.ctrl;
        REG_STATUS: next_r.rdata = {29'h0, r.done, (r.st != ACH_IDLE), busy_s};
        REG_SKEW:   next_r.rdata = r.skew;
        default:    next_r.rdata = 32'h0;
      endcase
    end
    // A write lands on the edge at which waitrequest is seen low
    if (avs_write && r.ack) begin
      if (avs_address == REG_CTRL) begin
        next_r.ctrl = avs_writedata & 32'h0000_001f;
        if (avs_writedata[CTRL_RESET] && r.st == ACH_IDLE) begin
          next_r.st   = ACH_RST; // RL5 RL6
          next_r.rstp = 1'b1;
          next_r.cnt  = 32'(RESET_PULSE_CYC - 1);
        end else if (avs_writedata[CTRL_CONVERT] && r.st == ACH_IDLE && !busy_s) begin
          next_r.st   = ACH_TRIG_A;
          next_r.ta   = 1'b1;
          next_r.tb   = ~avs_writedata[CTRL_SPLIT]; // RL11
          next_r.done = 1'b0;
          next_r.seen_busy = 1'b0;
        end
      end else if (avs_address == REG_SKEW) begin
        next_r.skew = avs_writedata;
      end
    end
    case (r.st)
      ACH_IDLE: ;
      ACH_RST: begin
        if (r.cnt == 32'h0) begin
          next_r.rstp = 1'b0;
          next_r.st   = ACH_IDLE;
        end
      end
      ACH_TRIG_A: begin
        // Triggers stay high until busy is seen, so the pin filter keeps them
        if (r.tb) begin
          next_r.st = ACH_WAIT;
        end else begin
          // Two cycles of state overhead count against the skew limit
          next_r.cnt = (r.skew < 32'(SET_SKEW_CYC - 2)) ? r.skew : 32'(SET_SKEW_CYC - 2); // RL14
          next_r.st  = ACH_GAP;
        end
      end
      ACH_GAP: begin
        if (r.cnt == 32'h0) begin
          next_r.tb = 1'b1;
          next_r.st = ACH_TRIG_B;
        end
      end
      ACH_TRIG_B: begin
        next_r.st = ACH_WAIT;
      end
      ACH_WAIT: begin
        if (busy_s) begin
          next_r.seen_busy = 1'b1;
          next_r.ta        = 1'b0;
          next_r.tb        = 1'b0;
        end else if (r.seen_busy) begin
          next_r.done = 1'b1;
          next_r.st   = ACH_IDLE;
        end
      end
      default: next_r.st = ACH_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r      <= '0;
      r.ctrl <= CTRL_RESET_VALUE;
      r.skew <= SKEW_RESET_VALUE;
    end else begin
      r <= next_r;
    end
  end

  assign link.power_down_request_n = r.ctrl[CTRL_POWER_DOWN_REQUEST_N_N];
  assign link.range                = r.ctrl[CTRL_RANGE];
  assign link.interface_select     = r.ctrl[CTRL_IF_SEL];
  assign link.byte_mode_select     = r.ctrl[CTRL_BYTE_SEL];
  assign link.adc_reset            = r.rstp;
  assign link.sample_trigger_a     = r.ta;
  assign link.sample_trigger_b     = r.tb;
  assign avs_readdata              = r.rdata;
  assign avs_waitrequest           = ~r.ack;
endmodule

// ---- acc_properties.sv ----
`timescale 1ns/1ps
module acc_properties #(
  parameter int unsigned CONV_CYC = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_down_request_n,
  input wire logic range,
  input wire logic adc_reset,
  input wire logic sample_trigger_a,
  input wire logic sample_trigger_b,
  input wire logic interface_select,
  input wire logic byte_mode_select,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] busy_len;
  logic [7:0]  since_a;
  logic [7:0]  since_b;
  logic        ta_q;
  logic        tb_q;
  // Saturating ages let the busy rise be tied to the later trigger edge
  always_ff @(posedge clk) begin
    busy_len <= busy ? busy_len + 32'h1 : 32'h0;
    ta_q     <= sample_trigger_a;
    tb_q     <= sample_trigger_b;
    since_a  <= rst ? 8'hff : (sample_trigger_a && !ta_q) ? 8'h00 : since_a + {7'h0, since_a != 8'hff};
    since_b  <= rst ? 8'hff : (sample_trigger_b && !tb_q) ? 8'h00 : since_b + {7'h0, since_b != 8'hff};
  end
  sequence s_reset_pulse;
    adc_reset [*4] ##1 !adc_reset;
  endsequence
  sequence s_split_start;
    $rose(sample_trigger_a) && !sample_trigger_b;
  endsequence
  a_busy_length: assert property ($fell(busy) |-> busy_len == CONV_CYC)
    else $error("busy width wrong");
  a_busy_later_edge: assert property ($rose(busy) |-> (since_a < 8'd12 || since_b < 8'd12)
    && since_a < 8'd140 && since_b < 8'd140 && since_a > 8'd1 && since_b > 8'd1)
    else $error("busy rise not tied to later trigger");
  a_busy_awake: assert property ($rose(busy) |-> power_down_request_n)
    else $error("conversion while powered down");
  a_trig_a_pulse: assert property ($rose(sample_trigger_a) |-> sample_trigger_a [*3])
    else $error("trigger a too short for the pin filter");
  a_trig_b_pulse: assert property ($rose(sample_trigger_b) |-> sample_trigger_b [*3])
    else $error("trigger b too short for the pin filter");
  a_split_skew: assert property (s_split_start |-> ##[1:125] $rose(sample_trigger_b))
    else $error("set skew exceeded");
  a_reset_pulse: assert property ($rose(adc_reset) |-> s_reset_pulse)
    else $error("reset pulse width wrong");
  a_trig_idle: assert property ($rose(sample_trigger_a) |-> !busy)
    else $error("trigger while busy");
endmodule

// ---- acc_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module acc_tb_top;
  import acc_pkg::*;
  localparam int unsigned CC = 20;
  localparam int unsigned SC = 30;
  localparam int unsigned HC = 40;
  logic        clk;
  logic        rst;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  hold;
  logic [1:0]  interface_mode;
  logic        span_10v;
  logic        ready;
  logic        results_valid;
  logic [31:0] conversion_count;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [31:0] cfg;
  int          mismatches;
  int          total_checks;
  int          exp_cnt;
  logic [7:0]  exp_hold[$];
  acc_link_if link();
  acc_host acc_host_i (.clk(clk), .rst(rst), .link(link), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  acc_device #(.CONV_CYC(CC), .POWER_DOWN_REQUEST_N_CYC(SC), .SHDN_CYC(HC), .CHANNELS(8)) acc_device_i (.clk(clk), .rst(rst),
    .link(link), .hold(hold), .interface_mode(interface_mode), .span_10v(span_10v), .ready(ready),
    .results_valid(results_valid), .conversion_count(conversion_count));
  acc_properties #(.CONV_CYC(CC)) acc_properties_i (.clk(clk), .rst(rst),
    .power_down_request_n(link.power_down_request_n), .range(link.range), .adc_reset(link.adc_reset),
    .sample_trigger_a(link.sample_trigger_a), .sample_trigger_b(link.sample_trigger_b),
    .interface_select(link.interface_select), .byte_mode_select(link.byte_mode_select), .busy(link.busy));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) mismatches++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // Bounded wait: 0 ready high, 1 busy low, 2 hold nonzero, 3 busy high
  task automatic wt(input int sel, input int lim);
    int n;
    n = 0;
    while (n < lim && !((sel == 0 && ready === 1'b1) || (sel == 1 && link.busy === 1'b0)
        || (sel == 2 && hold !== 8'h00) || (sel == 3 && link.busy === 1'b1))) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("[FAIL] t=%0t wait %h timed out", $time, sel);
    end
  endtask
  task automatic dev_reset(input logic [31:0] c);
    cfg = c;
    av(1'b1, REG_CTRL, c | 32'h40);
    // Ready may already stand from before; let the reset pulse pass the pin filter
    repeat (12) @(posedge clk);
    wt(0, 100);
    `CHK(interface_mode, {c[2], c[2] & c[3]})
    `CHK(span_10v, c[1])
    av(1'b0, REG_CTRL, 32'h0);
    `CHK(rd, c)
  endtask
  task automatic convert(input logic split);
    seed = xs(seed);
    av(1'b1, REG_SKEW, 32'h8 + {26'h0, seed[5:0]});
    av(1'b1, REG_CTRL, cfg | 32'h20 | {27'h0, split, 4'h0});
    exp_hold.push_back(split ? 8'h0f : 8'hff);
    wt(2, 300);
    `CHK(hold, exp_hold.pop_front())
    wt(3, 200);
    `CHK(hold, 8'hff)
    exp_cnt++;
    wt(1, CC + 10);
    repeat (2) @(posedge clk);
    `CHK(conversion_count, 32'(exp_cnt))
    `CHK(hold, 8'h00)
    `CHK(results_valid, 1'b1)
    repeat (4) @(posedge clk);
    av(1'b0, REG_STATUS, 32'h0);
    `CHK(rd, 32'h4)
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #(4 * 40000);
    mismatches++;
    close_out();
  end
  initial begin
    logic [3:0] straps[4];
    straps = '{4'h3, 4'h7, 4'hf, 4'h1};
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    seed = 32'h6c84;
    exp_cnt = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    av(1'b0, REG_CTRL, 32'h0);
    `CHK(rd, CTRL_RESET_VALUE)
    av(1'b0, REG_SKEW, 32'h0);
    `CHK(rd, SKEW_RESET_VALUE)
    av(1'b1, 4'hc, 32'hffff_ffff);
    av(1'b0, 4'hc, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(ready, 1'b0)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      dev_reset({28'h0, straps[i]});
      convert(i[0]);
    end
    $display("test modes done");
    av(1'b1, REG_CTRL, 32'h2);
    repeat (10) @(posedge clk);
    `CHK(ready, 1'b0)
    av(1'b1, REG_CTRL, 32'h3);
    repeat (SC / 2) @(posedge clk);
    `CHK(ready, 1'b0)
    wt(0, SC + 20);
    convert(1'b0);
    av(1'b1, REG_CTRL, 32'h0);
    repeat (10) @(posedge clk);
    av(1'b1, REG_CTRL, 32'h3);
    repeat (HC + 20) @(posedge clk);
    `CHK(ready, 1'b0)
    dev_reset(32'h3);
    convert(1'b1);
    $display("test power done");
    close_out();
  end
endmodule
